//--- hpd_pkg.sv
// Shared constants for the host port request, vector and DMA block
package hpd_pkg;
    localparam logic [2:0] ADDR_STATUS   = 3'h2;
    localparam logic [2:0] ADDR_VECTOR   = 3'h3;
    localparam logic [2:0] ADDR_BYTE_HI  = 3'h6;
    localparam logic [2:0] ADDR_BYTE_LO  = 3'h7;
    localparam logic       DMA_ADDR_TOP  = 1'h1;
    localparam logic [1:0] CNT_LAST      = 2'h3;
    localparam logic [1:0] CNT_ZERO      = 2'h0;
    localparam logic [7:0] VECTOR_RESET  = 8'h0F;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h06;
    localparam int         ST_REQ        = 7;
    localparam int         ST_DMA        = 6;
    localparam int         ST_TX_READY   = 2;
    localparam int         ST_TXE        = 1;
    localparam int         ST_RXF        = 0;
    localparam int         WORD_W        = 16;
    localparam int         FIFO_DEPTH    = 8;
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b01,
        ACK_BUSY = 2'b10
    } hpd_ack_e;
endpackage

//--- hpd_fifo.sv
// Word FIFO in front of the receive byte registers
`timescale 1ns/1ps
module hpd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             in_ready_next, out_valid_next, push, pop;

    always_comb begin
        push           = in_valid && in_ready;
        pop            = out_ready && out_valid;
        wr_next        = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next        = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next       = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        if (flush) begin
            wr_next  = '0;
            rd_next  = '0;
            cnt_next = '0;
        end
        in_ready_next  = cnt_next != (AW+1)'(DEPTH);
        out_valid_next = cnt_next != '0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else if (ce) begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            cnt_reg   <= cnt_next;
            in_ready  <= in_ready_next;
            out_valid <= out_valid_next;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push && !flush) begin
            mem[wr_reg] <= in_data;
        end
    end

    assign out_data = mem[rd_reg];

    chk_fifo_count_bound: assert property (@(posedge clk) disable iff (srst)
        cnt_reg <= (AW+1)'(DEPTH) && (in_ready == (cnt_reg != (AW+1)'(DEPTH))))
        else $error("FIFO count or ready flag inconsistent");
endmodule

//--- hpd_port.sv
// Host port request, exception vector and DMA handshake logic
`timescale 1ns/1ps
// Operation
// - Status bit 7 mirrors the request output pin.
// - Request asserts when enabled receive-full or transmit-empty flag is set.
// - Reset clears request status bit and deasserts the request pin.
// - Eight-bit vector register, host read/write only.
// - Vector drives host data when request and acknowledge asserted, DMA off.
// - Reset loads the vector register with 0F.
// - Core receive exception stays pending until the word is read; transmit exception until the FIFO is full.
// - Status shows request in bit 7, transmit-empty and receive-full in bits 1:0.
// - DMA moves one, two or three bytes per word (mode 3, 2, 1), register chosen by internal counter.
// - Host-to-core DMA requests while both transmit bytes are empty.
// - Acknowledge latches host data into counter-selected transmit byte, drops request.
// - Before the last byte, advance counter, await acknowledge release, request again.
// - After last byte reload counter; move bytes to core word when it is empty.
// - Core receive exception follows receive-full flag; reading the word clears it.
// - Core transmit exception while its enable and transmit-empty flag are set.
// - Empty receive bytes are refilled from core word, counter reloaded, flag set.
// - Receive bytes full asserts request; acknowledge drives selected byte, drops request.
// - Advance after acknowledge ends; after last byte wait for a new core word.
// - Either mode bit set means DMA; acknowledge is then the DMA acknowledge.
// - Two-bit counter replaces low address bits, top bit one, starts at mode.
// - Initialise always loads counter and clears channels per request enables.
module hpd_port (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [2:0]  host_addr_pins,
    input  wire logic        host_select_pin_n,
    input  wire logic        host_dir_pin,
    input  wire logic [7:0]  host_data_in,
    output logic [7:0]       host_data_out,
    output logic             host_data_oe,
    output logic             request_out_pin,
    input  wire logic        acknowledge_in_pin_n,
    input  wire logic        transfer_mode_high,
    input  wire logic        transfer_mode_low,
    input  wire logic        tx_request_enable,
    input  wire logic        rx_request_enable,
    input  wire logic        init_cmd,
    input  wire logic        dsp_tx_irq_enable,
    input  wire logic        dsp_rx_irq_enable,
    input  wire logic [15:0] dsp_transmit_word,
    input  wire logic        dsp_transmit_valid,
    output logic             dsp_tx_empty,
    input  wire logic        dsp_receive_rd,
    output logic [15:0]      dsp_receive_word,
    output logic             dsp_rx_full,
    output logic             dsp_rx_exception,
    output logic             dsp_tx_exception,
    output logic [7:0]       port_status_reg
);
    logic [1:0]        mode_reg, mode_next;
    logic              txen_reg, txen_next, rxen_reg, rxen_next;
    logic [7:0]        vector_reg, vector_next;
    logic [7:0]        tx_hi_reg, tx_hi_next, tx_lo_reg, tx_lo_next;
    logic [7:0]        rx_hi_reg, rx_hi_next, rx_lo_reg, rx_lo_next;
    logic              txe_reg, txe_next, rxf_reg, rxf_next;
    logic              drx_next;
    logic [15:0]       drx_word_next;
    logic [1:0]        cnt_reg, cnt_next;
    logic              acc_prev_reg;
    hpd_pkg::hpd_ack_e ack_reg, ack_next;
    logic              req_next, oe_next, rx_exc_next, tx_exc_next;
    logic [7:0]        dout_next, status_next;
    logic              dma, h2d, d2h, acc, acc_start, ack, fifo_pop, fifo_flush;
    logic [2:0]        dma_addr;
    logic [15:0]       fifo_data;
    logic              fifo_valid;

    function automatic logic [7:0] rd_mux(input logic [2:0] a, input logic [7:0] st, input logic [7:0] vec,
                                          input logic [7:0] hi, input logic [7:0] lo);
        case (a)
            hpd_pkg::ADDR_STATUS:  rd_mux = st;
            hpd_pkg::ADDR_VECTOR:  rd_mux = vec;
            hpd_pkg::ADDR_BYTE_HI: rd_mux = hi;
            hpd_pkg::ADDR_BYTE_LO: rd_mux = lo;
            default:               rd_mux = hpd_pkg::BYTE_ZERO;
        endcase
    endfunction

    hpd_fifo #(
        .WIDTH (hpd_pkg::WORD_W),
        .DEPTH (hpd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .flush     (fifo_flush),
        .in_data   (dsp_transmit_word),
        .in_valid  (dsp_transmit_valid),
        .in_ready  (dsp_tx_empty),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_comb begin
        mode_next     = {transfer_mode_high, transfer_mode_low};
        txen_next     = tx_request_enable;
        rxen_next     = rx_request_enable;
        dma           = |mode_reg;
        h2d           = dma && txen_reg;
        d2h           = dma && rxen_reg && !txen_reg;
        dma_addr      = {hpd_pkg::DMA_ADDR_TOP, cnt_reg};
        acc           = !host_select_pin_n;
        acc_start     = acc && !acc_prev_reg;
        ack           = !acknowledge_in_pin_n;
        vector_next   = vector_reg;
        tx_hi_next    = tx_hi_reg;
        tx_lo_next    = tx_lo_reg;
        rx_hi_next    = rx_hi_reg;
        rx_lo_next    = rx_lo_reg;
        txe_next      = txe_reg;
        rxf_next      = rxf_reg;
        drx_next      = dsp_rx_full;
        drx_word_next = dsp_receive_word;
        cnt_next      = cnt_reg;
        ack_next      = ack_reg;
        fifo_pop      = 1'b0;
        fifo_flush    = 1'b0;
        // Plain host register accesses
        if (acc_start && !host_dir_pin) begin
            case (host_addr_pins)
                hpd_pkg::ADDR_VECTOR:  vector_next = host_data_in;
                hpd_pkg::ADDR_BYTE_HI: tx_hi_next = host_data_in;
                hpd_pkg::ADDR_BYTE_LO: begin
                    tx_lo_next = host_data_in;
                    txe_next   = 1'b0;
                end
                default: ;
            endcase
        end
        if (acc_start && host_dir_pin && host_addr_pins == hpd_pkg::ADDR_BYTE_LO) begin
            rxf_next = 1'b0;
        end
        // DMA acknowledge handshake
        case (ack_reg)
            hpd_pkg::ACK_IDLE: begin
                if (dma && ack) begin
                    ack_next = hpd_pkg::ACK_BUSY;
                    if (h2d) begin
                        if (dma_addr == hpd_pkg::ADDR_BYTE_HI) begin
                            tx_hi_next = host_data_in;
                        end else begin
                            tx_lo_next = host_data_in;
                        end
                        if (cnt_reg == hpd_pkg::CNT_LAST) begin
                            txe_next = 1'b0;
                            cnt_next = mode_reg;
                        end else begin
                            cnt_next = cnt_reg + 2'h1;
                        end
                    end
                end
            end
            hpd_pkg::ACK_BUSY: begin
                if (!ack) begin
                    ack_next = hpd_pkg::ACK_IDLE;
                    if (d2h) begin
                        if (cnt_reg == hpd_pkg::CNT_LAST) begin
                            rxf_next = 1'b0;
                            cnt_next = mode_reg;
                        end else begin
                            cnt_next = cnt_reg + 2'h1;
                        end
                    end
                end
            end
            default: ack_next = hpd_pkg::ACK_IDLE;
        endcase
        // Core read clears the receive flag; a new word landing later still sets it
        if (dsp_receive_rd) begin
            drx_next = 1'b0;
        end
        if (!txe_reg && !dsp_rx_full) begin
            drx_next      = 1'b1;
            drx_word_next = {tx_hi_reg, tx_lo_reg};
            txe_next      = 1'b1;
            if (h2d) begin
                cnt_next = mode_reg;
            end
        end
        if (!rxf_reg && fifo_valid) begin
            fifo_pop   = 1'b1;
            rx_hi_next = fifo_data[15:8];
            rx_lo_next = fifo_data[7:0];
            rxf_next   = 1'b1;
            if (d2h) begin
                cnt_next = mode_reg;
            end
        end
        if (init_cmd) begin
            cnt_next = dma ? mode_reg : hpd_pkg::CNT_ZERO;
            if (txen_reg) begin
                txe_next = 1'b1;
                drx_next = 1'b0;
            end
            if (rxen_reg) begin
                rxf_next   = 1'b0;
                fifo_flush = 1'b1;
                fifo_pop   = 1'b0;
            end
        end
        // Request pin
        if (h2d) begin
            req_next = txe_next && ack_next == hpd_pkg::ACK_IDLE;
        end else if (d2h) begin
            req_next = rxf_next && ack_next == hpd_pkg::ACK_IDLE;
        end else begin
            req_next = (rxf_next && rxen_reg) || (txe_next && txen_reg);
        end
        // Host data bus drive
        if (d2h && ack) begin
            oe_next   = 1'b1;
            dout_next = (dma_addr == hpd_pkg::ADDR_BYTE_HI) ? rx_hi_reg : rx_lo_reg;
        end else if (!dma && request_out_pin && ack) begin
            oe_next   = 1'b1;
            dout_next = vector_reg;
        end else if (acc && host_dir_pin) begin
            oe_next   = 1'b1;
            dout_next = rd_mux(host_addr_pins, port_status_reg, vector_reg, rx_hi_reg, rx_lo_reg);
        end else begin
            oe_next   = 1'b0;
            dout_next = hpd_pkg::BYTE_ZERO;
        end
        status_next                   = hpd_pkg::BYTE_ZERO;
        status_next[hpd_pkg::ST_REQ]  = req_next;
        status_next[hpd_pkg::ST_DMA]  = |mode_next;
        status_next[hpd_pkg::ST_TX_READY] = txe_next && !drx_next;
        status_next[hpd_pkg::ST_TXE]  = txe_next;
        status_next[hpd_pkg::ST_RXF]  = rxf_next;
        rx_exc_next = drx_next && dsp_rx_irq_enable;
        tx_exc_next = dsp_tx_empty && dsp_tx_irq_enable;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_reg         <= 2'h0;
            txen_reg         <= 1'b0;
            rxen_reg         <= 1'b0;
            vector_reg       <= hpd_pkg::VECTOR_RESET;
            tx_hi_reg        <= hpd_pkg::BYTE_ZERO;
            tx_lo_reg        <= hpd_pkg::BYTE_ZERO;
            rx_hi_reg        <= hpd_pkg::BYTE_ZERO;
            rx_lo_reg        <= hpd_pkg::BYTE_ZERO;
            txe_reg          <= 1'b1;
            rxf_reg          <= 1'b0;
            dsp_rx_full      <= 1'b0;
            dsp_receive_word <= 16'h0000;
            cnt_reg          <= hpd_pkg::CNT_ZERO;
            acc_prev_reg     <= 1'b0;
            ack_reg          <= hpd_pkg::ACK_IDLE;
            request_out_pin  <= 1'b0;
            host_data_oe     <= 1'b0;
            host_data_out    <= hpd_pkg::BYTE_ZERO;
            port_status_reg  <= hpd_pkg::STATUS_RESET;
            dsp_rx_exception <= 1'b0;
            dsp_tx_exception <= 1'b0;
        end else if (ce) begin
            mode_reg         <= mode_next;
            txen_reg         <= txen_next;
            rxen_reg         <= rxen_next;
            vector_reg       <= vector_next;
            tx_hi_reg        <= tx_hi_next;
            tx_lo_reg        <= tx_lo_next;
            rx_hi_reg        <= rx_hi_next;
            rx_lo_reg        <= rx_lo_next;
            txe_reg          <= txe_next;
            rxf_reg          <= rxf_next;
            dsp_rx_full      <= drx_next;
            dsp_receive_word <= drx_word_next;
            cnt_reg          <= cnt_next;
            acc_prev_reg     <= acc;
            ack_reg          <= ack_next;
            request_out_pin  <= req_next;
            host_data_oe     <= oe_next;
            host_data_out    <= dout_next;
            port_status_reg  <= status_next;
            dsp_rx_exception <= rx_exc_next;
            dsp_tx_exception <= tx_exc_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_dma_ack_held;
        (ce && dma && !acknowledge_in_pin_n) [*2];
    endsequence

    sequence s_vector_cycle;
        ce && !dma && request_out_pin && !acknowledge_in_pin_n;
    endsequence

    chk_req_status_mirror: assert property (port_status_reg[hpd_pkg::ST_REQ] == request_out_pin)
        else $error("Status request bit differs from request pin");
    chk_req_int_mode: assert property ($past(ce) && !$past(dma) |->
        request_out_pin == ((port_status_reg[hpd_pkg::ST_RXF] && $past(rxen_reg))
                         || (port_status_reg[hpd_pkg::ST_TXE] && $past(txen_reg))))
        else $error("Request pin does not follow enabled flags");
    chk_reset_values: assert property ($past(srst) |-> !request_out_pin && vector_reg == hpd_pkg::VECTOR_RESET)
        else $error("Reset values of request or vector wrong");
    chk_vector_drive: assert property (s_vector_cycle |=> host_data_oe && host_data_out == $past(vector_reg))
        else $error("Vector not driven during acknowledge");
    chk_ack_drops_req: assert property (ce && dma && !acknowledge_in_pin_n |=> !request_out_pin)
        else $error("Request not dropped on DMA acknowledge");
    chk_held_ack_no_req: assert property (s_dma_ack_held |=> !request_out_pin ##1 1'b1)
        else $error("Request raised while acknowledge still held");
    chk_rx_exc_flag: assert property ($past(ce) |-> dsp_rx_exception == (dsp_rx_full && $past(dsp_rx_irq_enable)))
        else $error("Receive exception does not follow receive flag");
    chk_read_clears: assert property (ce && dsp_receive_rd && dsp_rx_full && !init_cmd |=> !dsp_rx_full)
        else $error("Core read did not clear receive flag");
    chk_fill_reload: assert property (ce && d2h && !rxf_reg && fifo_valid && !init_cmd && ack_reg == hpd_pkg::ACK_IDLE
        |=> port_status_reg[hpd_pkg::ST_RXF] && cnt_reg == $past(mode_reg))
        else $error("Receive refill did not set flag or reload counter");
endmodule

//--- hpd_host_model.sv
// Host processor and external DMA controller model
`timescale 1ns/1ps
module hpd_host_model (
    input  wire logic       clk,
    input  wire logic       request_out_pin,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    output logic [2:0]      host_addr_pins,
    output logic            host_select_pin_n,
    output logic            host_dir_pin,
    output logic [7:0]      host_data_in,
    output logic            acknowledge_in_pin_n
);
    initial begin
        host_addr_pins       = 3'h0;
        host_select_pin_n    = 1'h1;
        host_dir_pin         = 1'h1;
        host_data_in         = 8'h00;
        acknowledge_in_pin_n = 1'h1;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Idle bus shows inverted values so nothing stale can match
    task automatic release_bus();
        host_select_pin_n    = 1'h1;
        acknowledge_in_pin_n = 1'h1;
        host_data_in         = ~host_data_in;
        host_addr_pins       = ~host_addr_pins;
    endtask

    task automatic access(input logic [2:0] a, input logic dir, input logic [7:0] wd, output logic [7:0] rd);
        host_addr_pins    = a;
        host_dir_pin      = dir;
        host_data_in      = wd;
        host_select_pin_n = 1'h0;
        step();
        step();
        // Undriven bus reads back inverted
        rd = host_data_oe ? host_data_out : ~host_data_out;
        release_bus();
        step();
        step();
    endtask

    // Waits for a request, then acknowledges one byte
    task automatic dma_ack(input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n  = 0;
        rd = 8'hXX;
        while (request_out_pin !== 1'h1 && n < 50) begin
            step();
            n++;
        end
        if (n < 50) begin
            host_data_in         = wd;
            acknowledge_in_pin_n = 1'h0;
            step();
            step();
            rd = host_data_oe ? host_data_out : ~host_data_out;
            release_bus();
            step();
        end
    endtask
endmodule

//--- hpd_port_bench.sv
// Self-checking bench for the host port request and DMA block
`timescale 1ns/1ps
module hpd_port_bench;
    logic        clk;
    logic        srst;
    logic        ce;
    logic [2:0]  host_addr_pins;
    logic        host_select_pin_n;
    logic        host_dir_pin;
    logic [7:0]  host_data_in;
    logic [7:0]  host_data_out;
    logic        host_data_oe;
    logic        request_out_pin;
    logic        acknowledge_in_pin_n;
    logic        transfer_mode_high;
    logic        transfer_mode_low;
    logic        tx_request_enable;
    logic        rx_request_enable;
    logic        init_cmd;
    logic        dsp_tx_irq_enable;
    logic        dsp_rx_irq_enable;
    logic [15:0] dsp_transmit_word;
    logic        dsp_transmit_valid;
    logic        dsp_tx_empty;
    logic        dsp_receive_rd;
    logic [15:0] dsp_receive_word;
    logic        dsp_rx_full;
    logic        dsp_rx_exception;
    logic        dsp_tx_exception;
    logic [7:0]  port_status_reg;
    logic [7:0]  d;
    int          num_errors;
    int          samples_checked;

    hpd_port dut_u (.clk, .srst, .ce, .host_addr_pins, .host_select_pin_n, .host_dir_pin,
        .host_data_in, .host_data_out, .host_data_oe, .request_out_pin, .acknowledge_in_pin_n,
        .transfer_mode_high, .transfer_mode_low, .tx_request_enable, .rx_request_enable,
        .init_cmd, .dsp_tx_irq_enable, .dsp_rx_irq_enable, .dsp_transmit_word,
        .dsp_transmit_valid, .dsp_tx_empty, .dsp_receive_rd, .dsp_receive_word, .dsp_rx_full,
        .dsp_rx_exception, .dsp_tx_exception, .port_status_reg);

    hpd_host_model host_u (.clk, .request_out_pin, .host_data_out, .host_data_oe, .host_addr_pins,
        .host_select_pin_n, .host_dir_pin, .host_data_in, .acknowledge_in_pin_n);

    always #20 clk = ~clk;

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pulse_init();
        init_cmd = 1'h1;
        step();
        init_cmd = 1'h0;
        step();
        step();
    endtask

    task automatic wait_rx_full();
        int n;
        n = 0;
        while (dsp_rx_full !== 1'h1 && n < 10) begin
            step();
            n++;
        end
    endtask

    task automatic t_reset();
        chk(16'(port_status_reg), 16'h0006);
        chk(16'(request_out_pin), 16'h0000);
        host_u.access(hpd_pkg::ADDR_VECTOR, 1'h1, 8'h00, d);
        chk(16'(d), 16'(hpd_pkg::VECTOR_RESET));
        chk(16'(host_data_oe), 16'h0000);
    endtask

    task automatic t_vector();
        host_u.access(hpd_pkg::ADDR_VECTOR, 1'h0, 8'hA5, d);
        host_u.access(hpd_pkg::ADDR_VECTOR, 1'h1, 8'h00, d);
        chk(16'(d), 16'h00A5);
        host_u.access(3'h4, 1'h1, 8'h00, d);
        chk(16'(d), 16'h0000);
        ce                = 1'h0;
        tx_request_enable = 1'h1;
        step();
        step();
        step();
        chk(16'(request_out_pin), 16'h0000);
        ce = 1'h1;
        step();
        step();
        step();
        chk(16'(request_out_pin), 16'h0001);
        host_u.access(hpd_pkg::ADDR_STATUS, 1'h1, 8'h00, d);
        chk(16'(d), 16'h0086);
        host_u.dma_ack(8'h00, d);
        chk(16'(d), 16'h00A5);
        tx_request_enable = 1'h0;
        step();
        step();
        step();
        chk(16'(request_out_pin), 16'h0000);
    endtask

    task automatic t_to_core();
        transfer_mode_high = 1'h1;
        tx_request_enable  = 1'h1;
        dsp_rx_irq_enable  = 1'h1;
        step();
        pulse_init();
        chk(16'(request_out_pin), 16'h0001);
        host_u.dma_ack(8'h12, d);
        chk(16'(d), 16'h00FF);
        host_u.dma_ack(8'h34, d);
        wait_rx_full();
        chk(dsp_receive_word, 16'h1234);
        step();
        chk(16'(dsp_rx_exception), 16'h0001);
        host_u.dma_ack(8'h56, d);
        host_u.dma_ack(8'h78, d);
        host_u.access(hpd_pkg::ADDR_STATUS, 1'h1, 8'h00, d);
        chk(16'(d), 16'h0040);
        dsp_receive_rd = 1'h1;
        step();
        dsp_receive_rd = 1'h0;
        wait_rx_full();
        chk(dsp_receive_word, 16'h5678);
        dsp_receive_rd = 1'h1;
        step();
        dsp_receive_rd = 1'h0;
        step();
        step();
        chk(16'({dsp_rx_full, dsp_rx_exception, request_out_pin}), 16'h0001);
        transfer_mode_low = 1'h1;
        step();
        pulse_init();
        host_u.dma_ack(8'h9A, d);
        wait_rx_full();
        chk(dsp_receive_word, 16'h569A);
        dsp_receive_rd = 1'h1;
        step();
        dsp_receive_rd     = 1'h0;
        transfer_mode_high = 1'h0;
        transfer_mode_low  = 1'h0;
        tx_request_enable  = 1'h0;
        step();
    endtask

    task automatic t_to_host();
        int          n;
        logic [15:0] w;
        transfer_mode_high = 1'h1;
        rx_request_enable  = 1'h1;
        dsp_tx_irq_enable  = 1'h1;
        step();
        pulse_init();
        chk(16'(dsp_tx_exception), 16'h0001);
        n = 0;
        dsp_transmit_valid = 1'h1;
        while (dsp_tx_empty === 1'h1 && n < 20) begin
            dsp_transmit_word = 16'hA000 + 16'(n);
            step();
            n++;
        end
        dsp_transmit_valid = 1'h0;
        step();
        step();
        chk(16'(n >= 8 && n <= 9), 16'h0001);
        chk(16'({dsp_tx_exception, request_out_pin}), 16'h0001);
        for (int i = 0; i < n; i++) begin
            w = 16'hA000 + 16'(i);
            host_u.dma_ack(8'h00, d);
            chk(16'(d), 16'(w[15:8]));
            host_u.dma_ack(8'h00, d);
            chk(16'(d), 16'(w[7:0]));
        end
        step();
        step();
        chk(16'({request_out_pin, dsp_tx_empty, dsp_tx_exception}), 16'h0003);
    endtask

    task automatic tally_and_finish();
        $display("Errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        clk                = 1'h0;
        srst               = 1'h1;
        ce                 = 1'h1;
        transfer_mode_high = 1'h0;
        transfer_mode_low  = 1'h0;
        tx_request_enable  = 1'h0;
        rx_request_enable  = 1'h0;
        init_cmd           = 1'h0;
        dsp_tx_irq_enable  = 1'h0;
        dsp_rx_irq_enable  = 1'h0;
        dsp_transmit_word  = 16'h0000;
        dsp_transmit_valid = 1'h0;
        dsp_receive_rd     = 1'h0;
        num_errors         = 0;
        samples_checked    = 0;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'h0;
        step();
        t_reset();
        t_vector();
        t_to_core();
        t_to_host();
        tally_and_finish();
    end

    initial begin
        #(40 * 5000);
        num_errors++;
        tally_and_finish();
    end
endmodule
